// *** core/hka_pkg.sv ***
/*
 * Constants and types for the housekeeping converter sequencer.
 * Assumes an 8-bit special function register space.
 */
package hka_pkg;
    // Register offsets
    localparam logic [7:0] TEMP_RESULT_ADDR   = 8'hd7;
    localparam logic [7:0] CONV_START_ADDR    = 8'hd8;
    localparam logic [7:0] BATT_RESULT_ADDR   = 8'hdf;
    localparam logic [7:0] PWR_IRQ_EN_ADDR    = 8'hec;
    localparam logic [7:0] EXTV_RESULT_ADDR   = 8'hef;
    localparam logic [7:0] DELTA_ADDR         = 8'hf3;
    localparam logic [7:0] PWR_IRQ_FLAG_ADDR  = 8'hf8;
    localparam logic [7:0] INTERVAL_ADDR      = 8'hf9;
    localparam logic [7:0] LOW_BATT_THR_ADDR  = 8'hfa;
    // Reset values
    localparam logic [7:0] REG_RESET          = 8'h00;
    // Start bit positions
    localparam int BATT_START_BIT = 0;
    localparam int TEMP_START_BIT = 1;
    localparam int EXTV_START_BIT = 2;
    // Flag and enable bit positions
    localparam int LOW_BATT_FLAG_BIT = 0;
    localparam int EXTV_FLAG_BIT     = 1;
    // Field positions: delta and interval
    localparam int TEMP_DELTA_LSB  = 0;
    localparam int EXTV_DELTA_LSB  = 3;
    localparam int BATT_IVAL_LSB   = 0;
    localparam int EXTV_IVAL_LSB   = 2;
    localparam int TEMP_IVAL_LSB   = 4;
    // Delta code meaning every sample interrupts
    localparam logic [2:0] DELTA_EVERY = 3'h7;
    // Converter select codes
    localparam logic [1:0] SEL_BATT = 2'h0;
    localparam logic [1:0] SEL_TEMP = 2'h1;
    localparam logic [1:0] SEL_EXTV = 2'h2;
    // Power states
    localparam logic [1:0] FULL_POWER_STATE    = 2'h0;
    localparam logic [1:0] BATTERY_ACTIVE_STATE = 2'h1;
    localparam logic [1:0] CORE_HALTED_STATE   = 2'h2;
    // Background base tick: 1 ms at 100 MHz
    localparam int CLK_MHZ      = 100;
    localparam int BG_TICK_US   = 1000;
    localparam int BG_TICK_CYCLES = BG_TICK_US * CLK_MHZ;

    typedef enum logic [1:0] {
        HKA_IDLE,
        HKA_REQ,
        HKA_WAIT
    } hka_seq_t;
endpackage : hka_pkg

// *** core/hka_chan_if.sv ***
/*
 * Link between the sequencer and a change-detect channel.
 * Assumes both ends share the sequencer clock.
 */
`timescale 1ns/100ps
interface hka_chan_if;
    logic       sample_valid;  // Conversion finished
    logic       from_single;   // Started by software request
    logic [7:0] sample;        // Converted code
    logic [2:0] delta_code;    // Programmed delta
    logic       fire;          // Result must interrupt

    modport seq  (output sample_valid, from_single, sample, delta_code,
                  input fire);
    modport chan (input sample_valid, from_single, sample, delta_code,
                  output fire);
endinterface : hka_chan_if

// *** core/hka_chan.sv ***
/*
 * Change-detect channel: keeps the last interrupting code and decides
 * whether a new sample interrupts. Assumes sample_valid is one cycle.
 */
`timescale 1ns/100ps
module hka_chan (
    input  wire logic core_clk_i,   // System clock
    input  wire logic reset_i,      // Async reset, active high
    hka_chan_if.chan  link          // Sequencer side
);
    logic [7:0] last_q;
    logic [7:0] abs_diff;
    logic       over_delta;

    assign abs_diff = (link.sample > last_q) ? link.sample - last_q
                                             : last_q - link.sample;
    assign over_delta = (link.delta_code == hka_pkg::DELTA_EVERY) ||
                        (abs_diff > {5'h00, link.delta_code});
    assign link.fire = link.sample_valid &&
                       (link.from_single || over_delta);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            last_q <= hka_pkg::REG_RESET;
        end else if (link.fire) begin
            last_q <= link.sample;
        end
    end
endmodule : hka_chan

// *** core/hka_seq.sv ***
/*
 * Housekeeping converter sequencer: special function registers, power
 * state gating, background scheduling, arbitration and result update.
 * Assumes an external converter that accepts a request with ack and
 * later returns one code with done, and a core that writes and reads
 * registers with one-cycle strobes.
 */
`timescale 1ns/100ps
module hka_seq #(
    parameter int TICK_CYCLES = hka_pkg::BG_TICK_CYCLES
) (
    input  wire logic       core_clk_i,    // System clock
    input  wire logic       reset_i,       // Async reset, active high
    input  wire logic [7:0] sfr_addr_i,    // Register address
    input  wire logic [7:0] sfr_wdata_i,   // Write data
    input  wire logic       sfr_wr_i,      // Write strobe
    output logic      [7:0] sfr_rdata_o,   // Read data, registered
    input  wire logic [1:0] power_state_i, // Power state code
    output logic            conv_req_o,    // Converter request
    output logic      [1:0] conv_sel_o,    // Converter select
    input  wire logic       conv_ack_i,    // Request accepted
    input  wire logic       conv_done_i,   // Conversion done
    input  wire logic [7:0] conv_data_i,   // Conversion code
    output logic            temp_irq_o,    // Temperature irq pulse
    output logic            extv_irq_o,    // External irq pulse
    output logic            psm_irq_o      // Supply monitor irq
);
    hka_pkg::hka_seq_t state_q;
    logic [7:0] temp_result_q, batt_result_q, extv_result_q;
    logic [2:0] start_q;
    logic [7:0] irq_en_q, delta_q, interval_q, thr_q;
    logic [1:0] flags_q;
    logic [2:0] bg_pend_q;
    logic [31:0] cnt_q [3];
    logic [1:0] cur_sel_q;
    logic       cur_single_q;
    logic       temp_irq_q, extv_irq_q, psm_irq_q, conv_req_q;
    logic [7:0] rdata_q;

    // Interval field of a channel, zero meaning off
    function automatic logic [1:0] ival_code(input logic [7:0] iv,
                                             input int ch);
        if (ch == 0) begin
            return iv[hka_pkg::BATT_IVAL_LSB +: 2];
        end else if (ch == 1) begin
            return iv[hka_pkg::TEMP_IVAL_LSB +: 2];
        end
        return iv[hka_pkg::EXTV_IVAL_LSB +: 2];
    endfunction : ival_code

    // Interval length grows four times per code step
    function automatic logic [31:0] ival_len(input logic [1:0] code);
        return 32'(TICK_CYCLES) << (2 * (32'(code) - 32'd1));
    endfunction : ival_len

    // Register decode
    wire wr_start  = sfr_wr_i && (sfr_addr_i == hka_pkg::CONV_START_ADDR);
    wire wr_en     = sfr_wr_i && (sfr_addr_i == hka_pkg::PWR_IRQ_EN_ADDR);
    wire wr_delta  = sfr_wr_i && (sfr_addr_i == hka_pkg::DELTA_ADDR);
    wire wr_flags  = sfr_wr_i && (sfr_addr_i == hka_pkg::PWR_IRQ_FLAG_ADDR);
    wire wr_ival   = sfr_wr_i && (sfr_addr_i == hka_pkg::INTERVAL_ADDR);
    wire wr_thr    = sfr_wr_i && (sfr_addr_i == hka_pkg::LOW_BATT_THR_ADDR);

    logic [7:0] rd_mux;
    always_comb begin
        if (sfr_addr_i == hka_pkg::TEMP_RESULT_ADDR) begin
            rd_mux = temp_result_q;
        end else if (sfr_addr_i == hka_pkg::CONV_START_ADDR) begin
            rd_mux = {5'h00, start_q};
        end else if (sfr_addr_i == hka_pkg::BATT_RESULT_ADDR) begin
            rd_mux = batt_result_q;
        end else if (sfr_addr_i == hka_pkg::PWR_IRQ_EN_ADDR) begin
            rd_mux = irq_en_q;
        end else if (sfr_addr_i == hka_pkg::EXTV_RESULT_ADDR) begin
            rd_mux = extv_result_q;
        end else if (sfr_addr_i == hka_pkg::DELTA_ADDR) begin
            rd_mux = delta_q;
        end else if (sfr_addr_i == hka_pkg::PWR_IRQ_FLAG_ADDR) begin
            rd_mux = {6'h00, flags_q};
        end else if (sfr_addr_i == hka_pkg::INTERVAL_ADDR) begin
            rd_mux = interval_q;
        end else if (sfr_addr_i == hka_pkg::LOW_BATT_THR_ADDR) begin
            rd_mux = thr_q;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Power state gating of the two request sources
    wire single_ok = (power_state_i == hka_pkg::FULL_POWER_STATE) ||
                     (power_state_i == hka_pkg::BATTERY_ACTIVE_STATE);
    wire bg_ok     = (power_state_i == hka_pkg::FULL_POWER_STATE) ||
                     (power_state_i == hka_pkg::CORE_HALTED_STATE);
    wire [2:0] single_req = single_ok ? start_q : 3'h0;
    wire [2:0] bg_req     = bg_ok ? bg_pend_q : 3'h0;

    // Fixed priority: software first, then battery, temperature, external
    logic [1:0] grant_sel;
    logic       grant_single, grant_any;
    always_comb begin
        grant_any    = 1'b1;
        grant_single = 1'b1;
        grant_sel    = hka_pkg::SEL_BATT;
        if (single_req[hka_pkg::BATT_START_BIT]) begin
            grant_sel = hka_pkg::SEL_BATT;
        end else if (single_req[hka_pkg::TEMP_START_BIT]) begin
            grant_sel = hka_pkg::SEL_TEMP;
        end else if (single_req[hka_pkg::EXTV_START_BIT]) begin
            grant_sel = hka_pkg::SEL_EXTV;
        end else begin
            grant_single = 1'b0;
            if (bg_req[0]) begin
                grant_sel = hka_pkg::SEL_BATT;
            end else if (bg_req[1]) begin
                grant_sel = hka_pkg::SEL_TEMP;
            end else if (bg_req[2]) begin
                grant_sel = hka_pkg::SEL_EXTV;
            end else begin
                grant_any = 1'b0;
            end
        end
    end

    wire grant    = (state_q == hka_pkg::HKA_IDLE) && grant_any;
    wire accepted = (state_q == hka_pkg::HKA_REQ) && conv_ack_i;
    wire done     = (state_q == hka_pkg::HKA_WAIT) && conv_done_i;
    wire is_batt  = cur_sel_q == hka_pkg::SEL_BATT;
    wire is_temp  = cur_sel_q == hka_pkg::SEL_TEMP;
    wire is_extv  = cur_sel_q == hka_pkg::SEL_EXTV;

    // Change-detect channels for temperature and external voltage
    hka_chan_if temp_if ();
    hka_chan_if extv_if ();
    assign temp_if.sample_valid = done && is_temp;
    assign temp_if.from_single  = cur_single_q;
    assign temp_if.sample       = conv_data_i;
    assign temp_if.delta_code   = delta_q[hka_pkg::TEMP_DELTA_LSB +: 3];
    assign extv_if.sample_valid = done && is_extv;
    assign extv_if.from_single  = cur_single_q;
    assign extv_if.sample       = conv_data_i;
    assign extv_if.delta_code   = delta_q[hka_pkg::EXTV_DELTA_LSB +: 3];

    hka_chan u_temp_chan (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .link       (temp_if.chan)
    );
    hka_chan u_extv_chan (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .link       (extv_if.chan)
    );

    wire temp_fire = temp_if.fire;
    wire extv_fire = extv_if.fire;
    wire batt_set  = done && is_batt &&
                     (cur_single_q || (conv_data_i < thr_q));
    wire extv_set  = extv_fire && !cur_single_q;

    // Start bits: a write that sets wins over acceptance clear
    logic [2:0] start_clr, start_d;
    assign start_clr = (accepted && cur_single_q) ?
                       3'(3'h1 << cur_sel_q) : 3'h0;
    assign start_d   = (start_q & ~start_clr) |
                       (wr_start ? sfr_wdata_i[2:0] : 3'h0);

    // Flags: write zero clears, hardware set wins
    logic [1:0] flag_set, flags_d;
    assign flag_set = {extv_set, batt_set};
    assign flags_d  = (wr_flags ? (flags_q & sfr_wdata_i[1:0]) : flags_q) |
                      flag_set;
    wire psm_d = |(flags_q & irq_en_q[1:0]);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            start_q    <= 3'h0;
            irq_en_q   <= hka_pkg::REG_RESET;
            delta_q    <= hka_pkg::REG_RESET;
            interval_q <= hka_pkg::REG_RESET;
            thr_q      <= hka_pkg::REG_RESET;
            flags_q    <= 2'h0;
            rdata_q    <= 8'h00;
        end else begin
            start_q <= start_d;
            flags_q <= flags_d;
            rdata_q <= rd_mux;
            if (wr_en) begin
                irq_en_q <= sfr_wdata_i;
            end
            if (wr_delta) begin
                delta_q <= sfr_wdata_i;
            end
            if (wr_ival) begin
                interval_q <= sfr_wdata_i;
            end
            if (wr_thr) begin
                thr_q <= sfr_wdata_i;
            end
        end
    end

    // Results load only with their interrupt or flag
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            temp_result_q <= hka_pkg::REG_RESET;
            batt_result_q <= hka_pkg::REG_RESET;
            extv_result_q <= hka_pkg::REG_RESET;
            temp_irq_q    <= 1'b0;
            extv_irq_q    <= 1'b0;
            psm_irq_q     <= 1'b0;
        end else begin
            temp_irq_q <= temp_fire;
            extv_irq_q <= extv_fire;
            psm_irq_q  <= psm_d;
            if (temp_fire) begin
                temp_result_q <= conv_data_i;
            end
            if (batt_set) begin
                batt_result_q <= conv_data_i;
            end
            if (extv_fire) begin
                extv_result_q <= conv_data_i;
            end
        end
    end

    // Background interval counters; code zero stops the channel
    for (genvar ch = 0; ch < 3; ch++) begin : g_bg
        wire [1:0] code = ival_code(interval_q, ch);
        wire       tick = (code != 2'h0) &&
                          (cnt_q[ch] >= ival_len(code) - 32'd1);
        wire       taken = grant && !grant_single &&
                           (grant_sel == 2'(ch));
        always_ff @(posedge core_clk_i or posedge reset_i) begin
            if (reset_i) begin
                cnt_q[ch]     <= 32'd0;
                bg_pend_q[ch] <= 1'b0;
            end else begin
                cnt_q[ch]     <= (tick || code == 2'h0) ? 32'd0
                                                        : cnt_q[ch] + 32'd1;
                bg_pend_q[ch] <= tick || (bg_pend_q[ch] && !taken);
            end
        end
    end

    // Request sequence: hold request until accepted, then await done
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q      <= hka_pkg::HKA_IDLE;
            cur_sel_q    <= hka_pkg::SEL_BATT;
            cur_single_q <= 1'b0;
            conv_req_q   <= 1'b0;
        end else begin
            case (state_q)
                hka_pkg::HKA_IDLE: begin
                    if (grant) begin
                        state_q      <= hka_pkg::HKA_REQ;
                        cur_sel_q    <= grant_sel;
                        cur_single_q <= grant_single;
                        conv_req_q   <= 1'b1;
                    end
                end
                hka_pkg::HKA_REQ: begin
                    if (conv_ack_i) begin
                        state_q    <= hka_pkg::HKA_WAIT;
                        conv_req_q <= 1'b0;
                    end
                end
                default: begin
                    if (conv_done_i) begin
                        state_q <= hka_pkg::HKA_IDLE;
                    end
                end
            endcase
        end
    end

    assign sfr_rdata_o = rdata_q;
    assign conv_req_o  = conv_req_q;
    assign conv_sel_o  = cur_sel_q;
    assign temp_irq_o  = temp_irq_q;
    assign extv_irq_o  = extv_irq_q;
    assign psm_irq_o   = psm_irq_q;

    // Checks
    sequence s_accept_single;
        accepted && cur_single_q && !wr_start;
    endsequence
    property p_start_clear;
        @(posedge core_clk_i) disable iff (reset_i)
        s_accept_single |=> !start_q[$past(cur_sel_q)];
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("start bit not cleared on accept");

    property p_no_bg_batt_active;
        @(posedge core_clk_i) disable iff (reset_i)
        grant && power_state_i == hka_pkg::BATTERY_ACTIVE_STATE
        |-> grant_single;
    endproperty
    a_no_bg_batt_active: assert property (p_no_bg_batt_active)
        else $error("background grant in battery active state");

    property p_halted_bg_only;
        @(posedge core_clk_i) disable iff (reset_i)
        grant && power_state_i == hka_pkg::CORE_HALTED_STATE
        |-> !grant_single;
    endproperty
    a_halted_bg_only: assert property (p_halted_bg_only)
        else $error("software grant while core halted");

    property p_temp_hold;
        @(posedge core_clk_i) disable iff (reset_i)
        !temp_irq_q |-> $stable(temp_result_q);
    endproperty
    a_temp_hold: assert property (p_temp_hold)
        else $error("temperature result changed without irq");

    property p_temp_single_irq;
        @(posedge core_clk_i) disable iff (reset_i)
        done && is_temp && cur_single_q |=> temp_irq_q;
    endproperty
    a_temp_single_irq: assert property (p_temp_single_irq)
        else $error("no temperature irq after single conversion");

    property p_batt_hold;
        @(posedge core_clk_i) disable iff (reset_i)
        $changed(batt_result_q) |-> flags_q[hka_pkg::LOW_BATT_FLAG_BIT];
    endproperty
    a_batt_hold: assert property (p_batt_hold)
        else $error("battery result changed without flag");

    property p_psm_gate;
        @(posedge core_clk_i) disable iff (reset_i)
        ##1 psm_irq_o == $past(|(flags_q & irq_en_q[1:0]));
    endproperty
    a_psm_gate: assert property (p_psm_gate)
        else $error("supply monitor irq not gated by enables");

    property p_extv_hold;
        @(posedge core_clk_i) disable iff (reset_i)
        $changed(extv_result_q) |-> extv_irq_q;
    endproperty
    a_extv_hold: assert property (p_extv_hold)
        else $error("external result changed without irq");

    property p_req_hold;
        @(posedge core_clk_i) disable iff (reset_i)
        conv_req_q && !conv_ack_i |=> conv_req_q && $stable(cur_sel_q);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before acceptance");
endmodule : hka_seq

// *** tb/hka_conv_model.sv ***
/*
 * Converter model: acks a request, later returns one code with done.
 * Assumes requests follow the sequencer's req/ack/done handshake.
 */
`timescale 1ns/100ps
module hka_conv_model (
    input  wire logic       core_clk_i, // System clock
    input  wire logic       reset_i,    // Async reset
    input  wire logic       req_i,      // Conversion request
    input  wire logic [3:0] lat_i,      // Answer latency
    input  wire logic [7:0] code_i,     // Code to return
    output logic            ack_o,      // Request accepted
    output logic            done_o,     // Conversion done
    output logic      [7:0] data_o      // Code, valid with done
);
    logic [3:0] cnt_q;
    logic       busy_q;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            {cnt_q, busy_q, ack_o, done_o, data_o} <= '0;
        end else begin
            ack_o  <= 1'b0;
            done_o <= 1'b0;
            // Data not valid outside done: keep it moving
            data_o <= ~data_o;
            if (busy_q || (req_i && !ack_o)) begin
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == lat_i) begin
                    cnt_q  <= 4'h0;
                    busy_q <= !busy_q;
                    ack_o  <= !busy_q;
                    done_o <= busy_q;
                    if (busy_q) data_o <= code_i;
                end
            end
        end
    end
endmodule : hka_conv_model

// *** tb/hka_seq_tb.sv ***
/*
 * Self-checking bench for the sequencer: register reads are queued
 * and compared by a monitor. Assumes TICK_CYCLES of 8.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    error_cnt++; $display("mismatch %s exp %h got %h", n, e, g); end end
module hka_seq_tb;
    logic clk = 0, rst = 1, wr = 0, rd_vld = 0, req, ack, done, t_irq;
    logic e_irq, psm;
    logic [7:0] addr = 0, wdata = 0, rdata, code = 0, c0, dat, e;
    logic [1:0] pst = 0, sel;
    logic [3:0] lat = 0;
    logic [7:0] rq[$];
    logic [7:0] rd_list [10] = '{8'hd7, 8'hd8, 8'hdf, 8'hec, 8'hef,
                                 8'hf3, 8'hf8, 8'hf9, 8'hfa, 8'h00};
    int error_cnt = 0, total_checks = 0, nt = 0, ne = 0, nreq = 0, k;
    hka_seq #(.TICK_CYCLES(8)) hka_seq_inst (.core_clk_i(clk),
        .reset_i(rst), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
        .sfr_wr_i(wr), .sfr_rdata_o(rdata), .power_state_i(pst),
        .conv_req_o(req), .conv_sel_o(sel), .conv_ack_i(ack),
        .conv_done_i(done), .conv_data_i(dat), .temp_irq_o(t_irq),
        .extv_irq_o(e_irq), .psm_irq_o(psm));
    hka_conv_model hka_conv_model_inst (.core_clk_i(clk), .reset_i(rst),
        .req_i(req), .lat_i(lat), .code_i(code), .ack_o(ack),
        .done_o(done), .data_o(dat));
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        if (rd_vld) begin
            e = rq.pop_front();
            `CHK("rdata", e, rdata)
        end
        nt <= nt + (t_irq === 1'b1);
        ne <= ne + (e_irq === 1'b1);
        nreq <= nreq + (req === 1'b1 && ack === 1'b1);
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge clk);
        addr <= a;
        rq.push_back(x);
        @(posedge clk);
        rd_vld <= 1'b1;
        @(posedge clk);
        rd_vld <= 1'b0;
    endtask : rd
    task automatic wait_done;
        int n;
        n = 0;
        do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 400);
        if (n >= 400) `CHK("done", 1'b1, 1'b0)
        // Three edges: results settled, next request still standing
        repeat (3) @(posedge clk);
    endtask : wait_done
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    initial begin
        #100000;
        error_cnt++;
        conclude();
    end
    initial begin
        k = $urandom(39305);
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (k = 0; k < 10; k++) rd(rd_list[k], 8'h00);
        c0 = 8'($urandom);
        wr_reg(8'hfa, c0);
        rd(8'hfa, c0);
        c0 = 8'($urandom_range(0, 240));
        code <= c0;
        wr_reg(8'hd8, 8'h07);
        for (k = 0; k < 3; k++) begin
            do @(negedge clk); while (req !== 1'b1);
            `CHK("sel", 2'(k), sel)
            wait_done();
        end
        rd(8'hdf, c0);
        rd(8'hd7, c0);
        rd(8'hef, c0);
        rd(8'hf8, 8'h01);
        rd(8'hd8, 8'h00);
        `CHK("irqs", 64'h1_0000_0001, {32'(nt), 32'(ne)})
        wr_reg(8'hec, 8'h01);
        repeat (3) @(posedge clk);
        `CHK("psm", 1'b1, psm)
        wr_reg(8'hf8, 8'h00);
        repeat (3) @(posedge clk);
        `CHK("psm", 1'b0, psm)
        pst <= 2'h1; lat <= 4'h6; code <= c0 + 8'h9;
        wr_reg(8'hd8, 8'h02);
        wait_done();
        rd(8'hd7, c0 + 8'h9);
        pst <= 2'h2;
        wr_reg(8'hd8, 8'h02);
        repeat (60) @(posedge clk);
        rd(8'hd8, 8'h02);
        `CHK("temp", 2, nt)
        pst <= 2'h0;
        wait_done();
        `CHK("temp", 3, nt)
        pst <= 2'h2; lat <= 4'h0; code <= c0 + 8'h3;
        wr_reg(8'hf3, 8'h10);
        wr_reg(8'hf9, 8'h04);
        wait_done();
        `CHK("extv", 2, ne)
        rd(8'hef, c0 + 8'h3);
        rd(8'hf8, 8'h02);
        code <= c0 + 8'h4;
        wait_done();
        `CHK("extv", 2, ne)
        rd(8'hef, c0 + 8'h3);
        pst <= 2'h1;
        repeat (8) @(posedge clk);
        k = nreq;
        repeat (80) @(posedge clk);
        `CHK("bg", k, nreq)
        wr_reg(8'hf9, 8'h00);
        pst <= 2'h0;
        repeat (40) @(posedge clk);
        // Background temperature: change of 5 beyond a zero delta
        k = nt;
        wr_reg(8'hf9, 8'h10);
        wait_done();
        wr_reg(8'hf9, 8'h00);
        repeat (40) @(posedge clk);
        `CHK("temp", k + 1, nt)
        rd(8'hd7, c0 + 8'h4);
        wr_reg(8'hf8, 8'h00);
        wr_reg(8'hfa, 8'h80);
        code <= 8'h40;
        wr_reg(8'hf9, 8'h01);
        wait_done();
        wr_reg(8'hf9, 8'h00);
        repeat (40) @(posedge clk);
        rd(8'hf8, 8'h01);
        rd(8'hdf, 8'h40);
        wr_reg(8'hf8, 8'h00);
        code <= 8'h90;
        wr_reg(8'hf9, 8'h01);
        wait_done();
        wr_reg(8'hf9, 8'h00);
        repeat (40) @(posedge clk);
        rd(8'hf8, 8'h00);
        rd(8'hdf, 8'h40);
        conclude();
    end
endmodule : hka_seq_tb
